/* bench/sdam_ctl.sv */
// Controller model standing in front of the memory stage; drives all command pins.
// Assumes callers sequence commands; every task moves pins just after a rising edge.
`timescale 1ns/1ps
module sdam_ctl (
    // Clock
    input  wire logic   sys_clk,
    // Command, bank and address
    output logic        chip_select_n,
    output logic        row_strobe_n,
    output logic        col_strobe_n,
    output logic        write_enable_n,
    output logic        bank_select_low,
    output logic        bank_select_high,
    output logic [11:0] address_inputs,
    // Masks and write data
    output logic        lower_byte_mask,
    output logic        upper_byte_mask,
    output logic [15:0] data_lines_in
);
    // ============================================================
    // Pins start deselected so nothing is decoded before the first call.
    initial
    begin
        {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 4'hf;
        {bank_select_high, bank_select_low, upper_byte_mask, lower_byte_mask} = 4'h0;
        address_inputs = 12'h000;
        data_lines_in = 16'h0000;
    end

    // One command for one edge; a following call replaces it at the next edge.
    task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                       input logic [1:0] m, input logic [15:0] d);
        @(posedge sys_clk);
        {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} <= c;
        {bank_select_high, bank_select_low} <= b;
        address_inputs <= a;
        {upper_byte_mask, lower_byte_mask} <= m;
        data_lines_in <= d;
    endtask : cmd

    // No-op cycles; released lines flip each cycle so stale values never look valid.
    task automatic idle(input int n);
        repeat (n) cmd(4'h7, 2'h0, ~address_inputs, 2'h0, ~data_lines_in);
    endtask : idle

    // Bring-up: precharge all, two refreshes, then load the mode word.
    task automatic init();
        cmd(4'h2, 2'h0, 12'h400, 2'h0, 16'h0000);
        idle(2);
        repeat (2) begin cmd(4'h1, 2'h0, 12'h000, 2'h0, 16'h0000); idle(2); end
        cmd(4'h0, 2'h0, 12'h020, 2'h0, 16'h0000);
        idle(2);
    endtask : init

    // Rows are opened before any access to the bank.
    task automatic open(input logic [1:0] b, input logic [11:0] row);
        cmd(4'h3, b, row, 2'h0, 16'h0000);
    endtask : open
endmodule : sdam_ctl

/* bench/sdam_sva.sv */
// Checker for the SDRAM address and mask stage, watching only the top ports.
// Assumes the standard strobe encodings and a bind from the bench top file.
`timescale 1ns/1ps
`include "sdam_regs.svh"
module sdam_sva #(
    parameter int DW        = 16,
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input wire logic                   sys_clk,
    input wire logic                   rst_n,
    // Command, bank and address
    input wire logic                   chip_select_n,
    input wire logic                   row_strobe_n,
    input wire logic                   col_strobe_n,
    input wire logic                   write_enable_n,
    input wire logic                   bank_select_low,
    input wire logic                   bank_select_high,
    input wire logic [`SDAM_ROW_W-1:0] address_inputs,
    // Masks and data
    input wire logic                   lower_byte_mask,
    input wire logic                   upper_byte_mask,
    input wire logic [DW-1:0]          data_lines_in,
    input wire logic [DW-1:0]          data_lines_out,
    input wire logic [DW-1:0]          data_lines_oe
);
    // ============================================================
    // Shadow of the mode word and open banks, so latency checks know what to expect.
    wire [3:0]  cmd_w  = {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n};
    wire [1:0]  bank_w = {bank_select_high, bank_select_low};
    wire [3:0]  bit_w  = 4'h1 << bank_w;
    wire        rd_w   = cmd_w == 4'h5;
    wire        ap_w   = (rd_w || cmd_w == 4'h4) && address_inputs[`SDAM_AP_BIT];
    wire        pall_w = cmd_w == 4'h2 && address_inputs[`SDAM_AP_BIT];
    logic [11:0] mode_r;
    logic [3:0]  open_r;
    wire [11:0] mode_nxt = (cmd_w == 4'h0) ? address_inputs : mode_r;
    wire [3:0]  open_nxt = (cmd_w == 4'h3) ? (open_r | bit_w) : pall_w ? 4'h0 :
                           (cmd_w == 4'h2 || ap_w) ? (open_r & ~bit_w) : open_r;
    wire        cl3_w  = mode_r[6:4] == `SDAM_CL3_CODE;
    wire        bl1_w  = mode_r[2:0] == 3'h0;

    // Shadow registers follow the synchronous reset like the device does.
    always_ff @(posedge sys_clk)
    begin
        mode_r <= rst_n ? mode_nxt : `SDAM_MODE_RST;
        open_r <= rst_n ? open_nxt : 4'h0;
    end

    // ============================================================
    // Port relations.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    reset_quiet_a: assert property ($rose(rst_n) |-> data_lines_oe == '0 && data_lines_out == '0)
        else $error("outputs not quiet after reset");
    lane_group_a: assert property (data_lines_oe[7:0] == {8{data_lines_oe[0]}}
        && data_lines_oe[15:8] == {8{data_lines_oe[8]}}) else $error("enables split inside a byte");
    low_mask_a: assert property (lower_byte_mask |-> ##3 data_lines_oe[7:0] == 8'h00)
        else $error("low byte driven after mask");
    high_mask_a: assert property (upper_byte_mask |-> ##3 data_lines_oe[15:8] == 8'h00)
        else $error("high byte driven after mask");
    read_cl2_a: assert property (rd_w && open_r[bank_w] && !cl3_w && !lower_byte_mask && !upper_byte_mask
        |-> ##3 data_lines_oe == {DW{1'b1}}) else $error("read data missing at latency two");
    read_cl3_a: assert property (rd_w && open_r[bank_w] && cl3_w && !lower_byte_mask && !upper_byte_mask
        ##1 !lower_byte_mask && !upper_byte_mask |-> ##3 data_lines_oe == {DW{1'b1}})
        else $error("read data missing at latency three");
    idle_quiet_a: assert property ((!rd_w && bl1_w) [*4] |=> data_lines_oe == '0)
        else $error("outputs driven with no read");
    pre_all_a: assert property (pall_w ##1 rd_w |-> ##2 (data_lines_oe == '0) [*3])
        else $error("read served after precharge all");
    hold_out_a: assert property ($past(rst_n) && data_lines_oe == '0 && $past(data_lines_oe) == '0
        |-> $stable(data_lines_out)) else $error("idle output changed");
endmodule : sdam_sva

/* bench/sdam_tb.sv */
// Self-checking bench for the SDRAM address and mask stage.
// Assumes the controller model and checker files are compiled first.
`timescale 1ns/1ps
`define CHK(a, e, m) begin total_checks++; if ((a) !== (e)) begin errors++; $display("MISMATCH t=%0t %s", $time, m); end end
module testbench;
    localparam logic [3:0] RD = 4'h5, WR = 4'h4, PRE = 4'h2, LMR = 4'h0;
    logic        sys_clk, rst_n, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n;
    logic        bank_select_low, bank_select_high, lower_byte_mask, upper_byte_mask;
    logic [11:0] address_inputs;
    logic [15:0] data_lines_in, data_lines_out, data_lines_oe;
    int          errors = 0, total_checks = 0, cl = 2;

    // ============================================================
    // Controller model and device.
    sdam_ctl sdam_ctl_i (.sys_clk(sys_clk), .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
        .col_strobe_n(col_strobe_n), .write_enable_n(write_enable_n), .bank_select_low(bank_select_low),
        .bank_select_high(bank_select_high), .address_inputs(address_inputs), .lower_byte_mask(lower_byte_mask),
        .upper_byte_mask(upper_byte_mask), .data_lines_in(data_lines_in));
    sdam_core sdam_core_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
        .write_enable_n(write_enable_n), .bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
        .address_inputs(address_inputs), .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask),
        .data_lines_in(data_lines_in), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));

    task automatic stop_test();
        if (errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    // Read, wait the latency, then judge the enables and the enabled lanes.
    task automatic rd(input logic [1:0] b, input logic [11:0] a, input logic [1:0] m,
                      input logic [15:0] ev, input logic [15:0] eoe);
        sdam_ctl_i.cmd(RD, b, a, m, 16'h0000);
        sdam_ctl_i.idle(cl + 1);
        #1;
        `CHK(data_lines_oe, eoe, "read enables")
        `CHK(data_lines_out & eoe, ev & eoe, "read data")
    endtask : rd

    // Each bank keeps its own word; masked lanes keep the old byte.
    task automatic t_banks_masks();
        for (int b = 0; b < 4; b++)
        begin
            sdam_ctl_i.open(b[1:0], 12'h5a5);
            sdam_ctl_i.cmd(WR, b[1:0], 12'h010, 2'b00, 16'h1230 + 16'(b));
        end
        for (int b = 0; b < 4; b++)
            rd(b[1:0], 12'h010, 2'b00, 16'h1230 + 16'(b), 16'hffff);
        sdam_ctl_i.cmd(WR, 2'h2, 12'h010, 2'b01, 16'hffff);
        rd(2'h2, 12'h010, 2'b00, 16'hff32, 16'hffff);
        sdam_ctl_i.cmd(WR, 2'h2, 12'h010, 2'b10, 16'h0000);
        sdam_ctl_i.cmd(WR, 2'h2, 12'h010, 2'b11, 16'h5555);
        rd(2'h2, 12'h010, 2'b00, 16'hff00, 16'hffff);
    endtask : t_banks_masks

    // Full twelve-bit rows, upper address bits outside the column, deselected write.
    task automatic t_rows();
        sdam_ctl_i.open(2'h1, 12'hfff);
        sdam_ctl_i.cmd(WR, 2'h1, 12'h0ff, 2'b00, 16'hbeef);
        sdam_ctl_i.idle(2);
        sdam_ctl_i.open(2'h1, 12'h7ff);
        sdam_ctl_i.cmd(WR, 2'h1, 12'h0ff, 2'b00, 16'h0bad);
        rd(2'h1, 12'h0ff, 2'b00, 16'h0bad, 16'hffff);
        sdam_ctl_i.open(2'h1, 12'hfff);
        sdam_ctl_i.cmd(4'hc, 2'h1, 12'h0ff, 2'b00, 16'h0000);
        rd(2'h1, 12'hbff, 2'b00, 16'hbeef, 16'hffff);
    endtask : t_rows

    // A mask on a read turns off only its own byte.
    task automatic t_read_mask();
        rd(2'h1, 12'h0ff, 2'b10, 16'h00ef, 16'h00ff);
        rd(2'h1, 12'h0ff, 2'b01, 16'hbe00, 16'hff00);
    endtask : t_read_mask

    // Auto precharge, single-bank precharge and precharge all close the right banks.
    task automatic t_precharge();
        rd(2'h0, 12'h410, 2'b00, 16'h1230, 16'hffff);
        sdam_ctl_i.idle(2);
        rd(2'h0, 12'h010, 2'b00, 16'h0000, 16'h0000);
        sdam_ctl_i.cmd(PRE, 2'h3, 12'h000, 2'b00, 16'h0000);
        rd(2'h3, 12'h010, 2'b00, 16'h0000, 16'h0000);
        rd(2'h2, 12'h010, 2'b00, 16'hff00, 16'hffff);
        sdam_ctl_i.cmd(PRE, 2'h2, 12'h400, 2'b00, 16'h0000);
        rd(2'h1, 12'h0ff, 2'b00, 16'h0000, 16'h0000);
    endtask : t_precharge

    // Latency three, two-beat burst that runs on through deselect with a mask.
    task automatic t_burst();
        sdam_ctl_i.cmd(LMR, 2'h0, 12'h231, 2'b00, 16'h0000);
        sdam_ctl_i.idle(2);
        sdam_ctl_i.open(2'h0, 12'h5a5);
        sdam_ctl_i.cmd(WR, 2'h0, 12'h011, 2'b00, 16'h5a5a);
        sdam_ctl_i.cmd(RD, 2'h0, 12'h010, 2'b00, 16'h0000);
        sdam_ctl_i.cmd(4'hf, 2'h0, 12'h000, 2'b00, 16'h0000);
        sdam_ctl_i.cmd(4'hf, 2'h0, 12'h000, 2'b10, 16'h0000);
        sdam_ctl_i.idle(2);
        #1;
        `CHK(data_lines_oe, 16'hffff, "first beat enables")
        `CHK(data_lines_out, 16'h1230, "first beat data")
        sdam_ctl_i.idle(1);
        #1;
        `CHK(data_lines_oe, 16'h00ff, "second beat enables")
        `CHK(data_lines_out[7:0], 8'h5a, "second beat data")
        sdam_ctl_i.cmd(PRE, 2'h0, 12'h400, 2'b00, 16'h0000);
        sdam_ctl_i.cmd(LMR, 2'h0, 12'h020, 2'b00, 16'h0000);
        sdam_ctl_i.idle(2);
    endtask : t_burst

    // ============================================================
    // Clock, reset, sequence and watchdog.
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial
    begin
        rst_n = 1'b0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        sdam_ctl_i.init();
        t_banks_masks();
        t_rows();
        t_read_mask();
        t_precharge();
        t_burst();
        stop_test();
    end

    // A hang costs at most a millisecond, far beyond the roughly 120 cycles needed.
    initial
    begin
        #1000000;
        errors++;
        stop_test();
    end
endmodule : testbench

bind sdam_core sdam_sva #(.DW(DW), .BUF_DEPTH(BUF_DEPTH)) sdam_sva_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
    .write_enable_n(write_enable_n), .bank_select_low(bank_select_low), .bank_select_high(bank_select_high),
    .address_inputs(address_inputs), .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask),
    .data_lines_in(data_lines_in), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));

/* include/sdam_pkg.sv */
// Types shared by the SDRAM address and mask stage.
// Assumes nothing beyond a SystemVerilog compiler.
package sdam_pkg;

    // ============================================================
    // Commands decoded from the strobes
    typedef enum logic [3:0] {
        SDAM_CMD_INHIBIT,
        SDAM_CMD_NOP,
        SDAM_CMD_ACT,
        SDAM_CMD_RD,
        SDAM_CMD_WR,
        SDAM_CMD_PRE,
        SDAM_CMD_REF,
        SDAM_CMD_LMR,
        SDAM_CMD_BST
    } sdam_cmd_e;

endpackage : sdam_pkg

/* include/sdam_regs.svh */
// Constants of the SDRAM address and mask stage: mode word fields, reset values, geometry.
// Assumes inclusion by bare name from files that need the figures.
`ifndef SDAM_REGS_SVH
`define SDAM_REGS_SVH

// ============================================================
// Mode word fields
`define SDAM_M_BL_LSB   0
`define SDAM_M_BL_MSB   2
`define SDAM_M_BT_BIT   3
`define SDAM_M_CL_LSB   4
`define SDAM_M_CL_MSB   6
`define SDAM_M_WB_BIT   9
`define SDAM_CL3_CODE   3'h3
`define SDAM_BL_FULL    3'h7
// Reset mode word: CAS latency 2, burst length 1, sequential.
`define SDAM_MODE_RST   12'h020

// ============================================================
// Address bit that carries auto precharge and precharge scope
`define SDAM_AP_BIT     10

// ============================================================
// Geometry
`define SDAM_BANKS      4
`define SDAM_ROW_W      12
`define SDAM_ROWS       4096

`endif

/* include/sdam_stream_if.sv */
// Valid/ready word stream between the write capture and the array.
// Assumes both ends run on the one system clock.
`timescale 1ns/1ps
interface sdam_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sdam_stream_if

/* src/sdam_core.sv */
// Address, bank select and data mask stage of a four-bank SDRAM, with its array.
// Assumes a controller that initializes the part and keeps command timing.
//
// Operation
// - Masked write lanes leave memory unchanged.
// - Read mask tri-states lanes two clocks later.
// - Lower mask owns low byte, upper high.
// - Narrow parts use upper mask only.
// - Bank select picks the addressed bank.
// - Activate latches twelve address bits as row.
// - Read/write column from low address bits.
// - Address bit ten requests auto precharge.
// - Precharge all when bit ten high.
// - Mode load stores address inputs.
// - 4096 rows, columns by organization.
// - All inputs registered on rising clock.
// - Activate then burst in programmed order.
// - Deselect ignores commands, bursts and mask continue.
// - Command from select and three strobes.
`timescale 1ns/1ps
`include "sdam_regs.svh"
module sdam_core #(
    parameter int DW       = 16,
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    // Command strobes, active low
    input  wire logic                    chip_select_n,
    input  wire logic                    row_strobe_n,
    input  wire logic                    col_strobe_n,
    input  wire logic                    write_enable_n,
    // Bank and address
    input  wire logic                    bank_select_low,
    input  wire logic                    bank_select_high,
    input  wire logic [`SDAM_ROW_W-1:0]  address_inputs,
    // Byte masks
    input  wire logic                    lower_byte_mask,
    input  wire logic                    upper_byte_mask,
    // Data lines, split into in, out and enable
    input  wire logic [DW-1:0]           data_lines_in,
    output      logic [DW-1:0]           data_lines_out,
    output      logic [DW-1:0]           data_lines_oe
);
    import sdam_pkg::*;

    localparam int COLW  = (DW == 4) ? 10 : (DW == 8) ? 9 : 8;
    localparam int NL    = (DW == 16) ? 2 : 1;
    localparam int LW    = DW / NL;
    localparam int AW    = 2 + `SDAM_ROW_W + COLW;
    localparam int PW    = AW + NL + DW;

    if (DW != 4 && DW != 8 && DW != 16)
    begin : g_bad_dw
        $error("sdam_core: DW must be 4, 8 or 16");
    end

    // ============================================================
    // Functions

    // Command from the registered strobes; a deselect hides everything.
    function automatic sdam_cmd_e cmd_of(input logic cs_n, input logic [2:0] s);
        sdam_cmd_e c;
        c = SDAM_CMD_INHIBIT;
        if (!cs_n)
        begin
            unique case (s)
                3'h0: c = SDAM_CMD_LMR;
                3'h1: c = SDAM_CMD_REF;
                3'h2: c = SDAM_CMD_PRE;
                3'h3: c = SDAM_CMD_ACT;
                3'h4: c = SDAM_CMD_WR;
                3'h5: c = SDAM_CMD_RD;
                3'h6: c = SDAM_CMD_BST;
                3'h7: c = SDAM_CMD_NOP;
            endcase
        end
        return c;
    endfunction : cmd_of

    // Block mask of a burst length code; full page spans the whole row.
    function automatic logic [COLW-1:0] len_mask(input logic [2:0] bl, input logic single);
        logic [COLW-1:0] m;
        m = '0;
        if (!single)
        begin
            unique case (bl)
                3'h1:    m = COLW'(1);
                3'h2:    m = COLW'(3);
                3'h3:    m = COLW'(7);
                3'h7:    m = '1;
                default: m = '0;
            endcase
        end
        return m;
    endfunction : len_mask

    // ============================================================
    // Input registers: every pin is taken on the rising edge.
    logic                   in_cs_n_r;
    logic [2:0]             in_str_r;
    logic [1:0]             in_bank_r;
    logic [`SDAM_ROW_W-1:0] in_addr_r;
    logic [1:0]             in_mask_r;
    logic [DW-1:0]          in_data_r;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            in_cs_n_r <= 1'b1;
            in_str_r  <= 3'h7;
            in_bank_r <= 2'h0;
            in_addr_r <= '0;
            in_mask_r <= 2'h0;
            in_data_r <= '0;
        end
        else
        begin
            in_cs_n_r <= chip_select_n;
            in_str_r  <= {row_strobe_n, col_strobe_n, write_enable_n};
            in_bank_r <= {bank_select_high, bank_select_low};
            in_addr_r <= address_inputs;
            in_mask_r <= {upper_byte_mask, lower_byte_mask};
            in_data_r <= data_lines_in;
        end
    end

    // ============================================================
    // Lane masks; narrow parts ignore the lower mask pin entirely.
    logic [NL-1:0] lane_mask;
    generate
        if (NL == 2)
        begin : g_wide
            assign lane_mask = in_mask_r;
        end
        else
        begin : g_narrow
            assign lane_mask = in_mask_r[1];
        end
    endgenerate

    // ============================================================
    // Command decode and state.
    logic [`SDAM_ROW_W-1:0] mode_r;
    logic [3:0]             bank_open_r;
    logic [`SDAM_ROW_W-1:0] open_row_r [`SDAM_BANKS];
    logic                   bst_act_r;
    logic                   bst_rd_r;
    logic                   bst_ap_r;
    logic [1:0]             bst_bank_r;
    logic [COLW-1:0]        bst_start_r;
    logic [COLW-1:0]        bst_cnt_r;

    wire sdam_cmd_e cmd    = cmd_of(in_cs_n_r, in_str_r);
    wire            ap_bit = in_addr_r[`SDAM_AP_BIT];
    wire            cl3    = (mode_r[`SDAM_M_CL_MSB:`SDAM_M_CL_LSB] == `SDAM_CL3_CODE);
    wire            il     = mode_r[`SDAM_M_BT_BIT];
    wire [2:0]      bl     = mode_r[`SDAM_M_BL_MSB:`SDAM_M_BL_LSB];

    // A read or write only starts on a bank that holds an open row.
    wire            is_rw   = (cmd == SDAM_CMD_RD) || (cmd == SDAM_CMD_WR);
    wire            new_rw  = is_rw && bank_open_r[in_bank_r];
    wire            is_pre  = (cmd == SDAM_CMD_PRE);
    wire            pre_hit = is_pre && (ap_bit || in_bank_r == bst_bank_r);

    // Current beat: the new command's first beat, or the running burst.
    wire            beat_go   = new_rw || bst_act_r;
    wire            beat_rd   = new_rw ? (cmd == SDAM_CMD_RD) : bst_rd_r;
    wire [1:0]      beat_bank = new_rw ? in_bank_r : bst_bank_r;
    wire [COLW-1:0] beat_s    = new_rw ? in_addr_r[COLW-1:0] : bst_start_r;
    wire [COLW-1:0] beat_n    = new_rw ? '0 : bst_cnt_r;
    wire            beat_ap   = new_rw ? ap_bit : bst_ap_r;
    wire [COLW-1:0] beat_m    = len_mask(bl, !beat_rd && mode_r[`SDAM_M_WB_BIT]);
    wire [COLW-1:0] seq_col   = (beat_s & ~beat_m) | ((beat_s + beat_n) & beat_m);
    wire [COLW-1:0] beat_col  = il ? (beat_s ^ beat_n) : seq_col;
    wire            beat_last = (beat_n == beat_m);
    wire [AW-1:0]   beat_addr = {beat_bank, open_row_r[beat_bank], beat_col};
    // A terminate or precharge of the bursting bank ends the burst early.
    wire            bst_stop  = !new_rw && ((cmd == SDAM_CMD_BST) || pre_hit);
    wire            ap_close  = beat_go && beat_last && beat_ap;

    // Mode word loads only from the address pins.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            mode_r <= `SDAM_MODE_RST;
        else if (cmd == SDAM_CMD_LMR)
            mode_r <= in_addr_r;
    end

    // Row bookkeeping per bank: activate opens, precharge closes.
    generate
        for (genvar b = 0; b < `SDAM_BANKS; b++)
        begin : g_bank
            wire hit = (in_bank_r == 2'(b));
            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                begin
                    bank_open_r[b] <= 1'b0;
                    open_row_r[b]  <= '0;
                end
                else if (cmd == SDAM_CMD_ACT && hit)
                begin
                    bank_open_r[b] <= 1'b1;
                    open_row_r[b]  <= in_addr_r;
                end
                else if ((is_pre && (ap_bit || hit)) || (ap_close && beat_bank == 2'(b)))
                    bank_open_r[b] <= 1'b0;
            end
        end
    endgenerate

    // Burst counter; a new read or write cuts off the one in progress.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            bst_act_r   <= 1'b0;
            bst_rd_r    <= 1'b0;
            bst_ap_r    <= 1'b0;
            bst_bank_r  <= 2'h0;
            bst_start_r <= '0;
            bst_cnt_r   <= '0;
        end
        else
        begin
            bst_act_r   <= beat_go && !beat_last && !bst_stop;
            bst_rd_r    <= beat_rd;
            bst_ap_r    <= beat_ap;
            bst_bank_r  <= beat_bank;
            bst_start_r <= beat_s;
            bst_cnt_r   <= beat_n + COLW'(1);
        end
    end

    // ============================================================
    // Write path: beats queue in a small buffer before the array.
    // The array is busy for a cycle on refresh and mode load, which
    // stalls the drain; the buffer keeps up to BUF_DEPTH of those words and drops a beat that finds it full.
    sdam_stream_if #(.W(PW)) wq_in ();
    sdam_stream_if #(.W(PW)) wq_out ();

    wire arr_busy = (cmd == SDAM_CMD_REF) || (cmd == SDAM_CMD_LMR);
    assign wq_in.valid  = beat_go && !beat_rd && !bst_stop && (lane_mask != '1);
    assign wq_in.data   = {beat_addr, lane_mask, in_data_r};
    assign wq_out.ready = !arr_busy;

    sdam_skid_buf #(.W(PW), .DEPTH(BUF_DEPTH)) u_wq (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .push    (wq_in),
        .pop     (wq_out)
    );

    wire            wr_en   = wq_out.valid && wq_out.ready;
    wire [AW-1:0]   wr_addr = wq_out.data[PW-1 -: AW];
    wire [NL-1:0]   wr_mask = wq_out.data[DW +: NL];
    wire [DW-1:0]   wr_data = wq_out.data[DW-1:0];
    wire            rd_en   = beat_go && beat_rd && !bst_stop;

    // ============================================================
    // Array, one memory per byte lane so a mask needs no read-modify-write.
    logic [DW-1:0] rdq_r;
    generate
        for (genvar l = 0; l < NL; l++)
        begin : g_lane
            logic [LW-1:0] mem [2**AW];
            always_ff @(posedge sys_clk)
            begin
                if (wr_en && !wr_mask[l])
                    mem[wr_addr] <= wr_data[l*LW +: LW];
            end
            always_ff @(posedge sys_clk)
            begin
                if (rd_en)
                    rdq_r[l*LW +: LW] <= mem[beat_addr];
            end
        end
    endgenerate

    // ============================================================
    // Read pipeline: the array read is one stage, latency 3 adds one more.
    logic          rv1_r;
    logic          rv2_r;
    logic [DW-1:0] rdq2_r;
    logic [NL-1:0] msk_d_r;
    wire           out_v = cl3 ? rv2_r : rv1_r;
    wire [DW-1:0]  out_d = cl3 ? rdq2_r : rdq_r;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rv1_r   <= 1'b0;
            rv2_r   <= 1'b0;
            rdq2_r  <= '0;
            msk_d_r <= '0;
        end
        else
        begin
            rv1_r   <= rd_en;
            rv2_r   <= rv1_r;
            rdq2_r  <= rdq_r;
            msk_d_r <= lane_mask;
        end
    end

    // Output flops; the mask delay lines up with the sampling edge.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            data_lines_out <= '0;
        else if (out_v)
            data_lines_out <= out_d;
    end

    generate
        for (genvar l = 0; l < NL; l++)
        begin : g_oe
            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                    data_lines_oe[l*LW +: LW] <= '0;
                else
                    data_lines_oe[l*LW +: LW] <= {LW{out_v && !msk_d_r[l]}};
            end
        end
    endgenerate
endmodule : sdam_core

/* src/sdam_skid_buf.sv */
// Small FIFO with a pass-through path when empty and the drain is ready.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module sdam_skid_buf #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic    sys_clk,
    input wire logic    rst_n,
    // Filling side
    sdam_stream_if.snk  push,
    // Draining side
    sdam_stream_if.src  pop
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("sdam_skid_buf: DEPTH must be a power of two, at least 2");
    end

    logic [W-1:0] store [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;

    // ============================================================
    // Handshake terms; an empty buffer passes the word straight through
    // so a write lands in the array on the edge after the input registers captured it.
    wire empty    = (cnt_r == '0);
    wire full     = (cnt_r == (AW+1)'(DEPTH));
    wire do_push  = push.valid && !full && !(empty && pop.ready);
    wire do_pop   = !empty && pop.ready;
    assign push.ready = !full;
    assign pop.valid  = !empty || push.valid;
    assign pop.data   = empty ? push.data : store[rp_r];

    // Storage and pointers.
    always_ff @(posedge sys_clk)
    begin
        if (do_push)
            store[wp_r] <= push.data;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wp_r  <= wp_r + AW'(do_push);
            rp_r  <= rp_r + AW'(do_pop);
            cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule : sdam_skid_buf
